// *** logic/adcrd_cfg.svh ***
// Named constants of the converter result readout block.
// Included by the register slave, the top and the bench; holds definitions only.
//
// Behaviour
// - Interface outputs float while unit-select or read-strobe is high.
// - Code-format select picks twos complement or straight binary results.
// - Serial-parallel select low uses the parallel bus; reads any phase.
// - Byte-order select low puts the low byte on D[7:0].
// - Byte-order select high swaps bytes for 8-bit hosts.
// - Serial mode shifts 16 result bits out, most significant first.
// - Each serial bit stays valid at both edges of the serial clock.
// - Clock-source select low makes the device drive clock and frame marker.
// - Master mode can invert serial clock and frame marker polarity.
// - In master mode read-timing selects shift after or during conversion.
// - Master read-after-conversion keeps busy high until 16 bits are out.
// - Slave mode takes host clock; shifts only with select and strobe low.
// - Slave read-after-conversion reads at any clock up to 40 MHz; here each host clock level must last over one 25 ns clk cycle to be seen.
// - Chain input is used only in slave read-after-conversion mode.
// - Chain input is latched on the edge opposite the shift edge.
// - Slave read-during-conversion pulses late-read when under 16 bits read.
// - A slave read may start after conversion and finish during the next.
// - Convert-start low begins a conversion that cannot be restarted.
// - Convert-start held low while idle restarts conversions automatically.
`ifndef ADCRD_CFG_SVH
`define ADCRD_CFG_SVH

// Register byte addresses on the AXI4-Lite port.
`define ADCRD_ADDR_W        8
`define ADCRD_REG_CTRL      8'h00
`define ADCRD_REG_STATUS    8'h04
`define ADCRD_REG_RESULT    8'h08
`define ADCRD_CTRL_RST      5'h00
`define ADCRD_RESP_OKAY     2'h0
`define ADCRD_RESP_SLVERR   2'h2

// Control register fields.
`define ADCRD_CTRL_W        5
`define ADCRD_B_FORMAT      0
`define ADCRD_B_BYTE_ORDER_SELECT    1
`define ADCRD_B_SERIAL      2
`define ADCRD_B_CLKSRC      3
`define ADCRD_B_INVERT      4

// Status register fields.
`define ADCRD_B_BUSY        0
`define ADCRD_B_LATE        1
`define ADCRD_B_MACTIVE     2
`define ADCRD_B_SCNT_LO     8

// Result width and timing.
`define ADCRD_BITS          16
`define ADCRD_MSB           15
`define ADCRD_CNT_W         5
`define ADCRD_CLK_NS        25
`define ADCRD_CONV_TIME_NS  2000
`define ADCRD_CONV_CYC      ((`ADCRD_CONV_TIME_NS + `ADCRD_CLK_NS - 1) / `ADCRD_CLK_NS)
`define ADCRD_CONV_W        8
`define ADCRD_SCLK_HALF     2'h1
`define ADCRD_PIN_N         5
`define ADCRD_PIN_RST       5'h1f

`endif

// *** logic/adcrd_pkg.sv ***
// Types shared by the converter result readout block.
// Assumes nothing of its surroundings.
`default_nettype none
package adcrd_pkg;
  // Conversion sequencer states, one-hot.
  typedef enum logic [2:0] {
    ADCRD_IDLE   = 3'b001,
    ADCRD_CONV   = 3'b010,
    ADCRD_MSHIFT = 3'b100
  } adcrd_state_t;
endpackage
`default_nettype wire

// *** logic/adcrd_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; reset value is constant.
`timescale 1ns/1ps
`default_nettype none
module adcrd_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_s
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= RST_VAL;
      pin_s  <= RST_VAL;
    end
    else
    begin
      meta_r <= pin_in;
      pin_s  <= meta_r;
    end
  end
endmodule // adcrd_sync
`default_nettype wire

// *** logic/adcrd_axil.sv ***
// AXI4-Lite register slave: control register, status and result readback.
// Assumes one write and one read in flight at most.
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_cfg.svh"
module adcrd_axil (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [`ADCRD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`ADCRD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [31:0]              status_in,
  input  wire logic [31:0]              result_in,
  output logic [`ADCRD_CTRL_W-1:0]      ctrl_r
);
  logic                     aw_got_r;
  logic                     w_got_r;
  logic [`ADCRD_ADDR_W-1:0] awaddr_r;
  logic [31:0]              wdata_r;
  logic                     wstrb0_r;

  // Address and data are taken in either order, one each per write.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end
    else if (aw_got_r && w_got_r)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
    end
  end

  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;

  // Commit the write and raise the response once both halves are in.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r       <= `ADCRD_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCRD_RESP_OKAY;
    end
    else if (aw_got_r && w_got_r)
    begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r == `ADCRD_REG_CTRL)
      begin
        s_axi_bresp <= `ADCRD_RESP_OKAY;
        if (wstrb0_r)
          ctrl_r <= wdata_r[`ADCRD_CTRL_W-1:0];
      end
      else
        s_axi_bresp <= `ADCRD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `ADCRD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `ADCRD_RESP_OKAY;
      unique case (s_axi_araddr)
        `ADCRD_REG_CTRL:   s_axi_rdata <= 32'(ctrl_r);
        `ADCRD_REG_STATUS: s_axi_rdata <= status_in;
        `ADCRD_REG_RESULT: s_axi_rdata <= result_in;
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `ADCRD_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // adcrd_axil
`default_nettype wire

// *** logic/adcrd_top.sv ***
// Result readout interface of a 16-bit sampling converter: conversion
// sequencing, parallel bus, master and slave serial link, chaining.
// Assumes conv_data comes from the converter core on clk; pins are async.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_cfg.svh"
module adcrd_top
  import adcrd_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [`ADCRD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`ADCRD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [`ADCRD_MSB:0]      conv_data,
  input  wire logic                     convert_start_n,
  input  wire logic                     cs_n,
  input  wire logic                     rd_n,
  input  wire logic                     read_timing_or_chain_input,
  input  wire logic                     sclk_in,
  output logic                          busy_r,
  output logic [`ADCRD_MSB:0]           data_out_r,
  output logic                          data_oe_r,
  output logic                          serial_data_output_r,
  output logic                          serial_oe_r,
  output logic                          sclk_out_r,
  output logic                          sclk_oe_r,
  output logic                          frame_valid_r,
  output logic                          late_read_flag_r
);
  logic [`ADCRD_CTRL_W-1:0]  ctrl_r;
  logic [`ADCRD_PIN_N-1:0]   pins_s;
  logic                      cnv_n_s;
  logic                      cs_n_s;
  logic                      rd_n_s;
  logic                      rtc_s;
  logic                      sclk_s;
  logic                      sclk_d_r;
  logic                      code_format_select;
  logic                      byte_order_select;
  logic                      serial_parallel_select;
  logic                      clock_source_select;
  logic                      clock_invert;
  logic                      selected;
  adcrd_state_t              state_r;
  logic [`ADCRD_CONV_W-1:0]  conv_cnt_r;
  logic                      conv_done;
  logic [`ADCRD_MSB:0]       result_r;
  logic [`ADCRD_MSB:0]       fmt_result;
  logic [`ADCRD_MSB:0]       fmt_new;
  logic                      m_start;
  logic                      m_active_r;
  logic                      m_level_r;
  logic [1:0]                m_half_r;
  logic [`ADCRD_CNT_W-1:0]   m_bits_r;
  logic [`ADCRD_MSB:0]       m_shift_r;
  logic                      m_done;
  logic [`ADCRD_MSB:0]       s_shift_r;
  logic [`ADCRD_CNT_W-1:0]   s_cnt_r;
  logic                      s_chain_r;
  logic                      s_rise;
  logic                      s_fall;
  logic                      late_seen_r;
  logic [31:0]               status_w;

  // Register slave on the AXI4-Lite port.
  adcrd_axil u_axil (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status_in     (status_w),
    .result_in     ({16'h0000, result_r}),
    .ctrl_r        (ctrl_r)
  );

  // All pin inputs pass two flops before any logic sees them.
  adcrd_sync #(
    .W       (`ADCRD_PIN_N),
    .RST_VAL (`ADCRD_PIN_RST)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({convert_start_n, cs_n, rd_n,
               read_timing_or_chain_input, sclk_in}),
    .pin_s   (pins_s)
  );

  assign {cnv_n_s, cs_n_s, rd_n_s, rtc_s, sclk_s} = pins_s;

  // Mode fields from the control register.
  assign code_format_select     = ctrl_r[`ADCRD_B_FORMAT];
  assign byte_order_select      = ctrl_r[`ADCRD_B_BYTE_ORDER_SELECT];
  assign serial_parallel_select = ctrl_r[`ADCRD_B_SERIAL];
  assign clock_source_select    = ctrl_r[`ADCRD_B_CLKSRC];
  assign clock_invert           = ctrl_r[`ADCRD_B_INVERT];
  assign selected               = ~(cs_n_s | rd_n_s);

  // Straight binary passes through; twos complement flips the top bit.
  assign fmt_result = code_format_select ? result_r
                    : {~result_r[`ADCRD_MSB], result_r[`ADCRD_MSB-1:0]};
  assign fmt_new = code_format_select ? conv_data
                 : {~conv_data[`ADCRD_MSB], conv_data[`ADCRD_MSB-1:0]};

  // Conversion completes when the cycle count runs out.
  assign conv_done = (state_r == ADCRD_CONV) && (conv_cnt_r == '0);

  // Master shift starts at conversion start or at conversion end.
  assign m_start = serial_parallel_select && !clock_source_select
                 && ((state_r == ADCRD_IDLE && !cnv_n_s && rtc_s)
                 || (conv_done && !rtc_s));

  // Conversion sequencer; a running conversion ignores convert-start.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r    <= ADCRD_IDLE;
      conv_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ADCRD_IDLE:
          if (!cnv_n_s)
          begin
            state_r    <= ADCRD_CONV;
            conv_cnt_r <= `ADCRD_CONV_W'(`ADCRD_CONV_CYC - 1);
          end
        ADCRD_CONV:
          if (conv_done)
            state_r <= m_start ? ADCRD_MSHIFT : ADCRD_IDLE;
          else
            conv_cnt_r <= conv_cnt_r - 1'b1;
        ADCRD_MSHIFT:
          if (m_done)
            state_r <= ADCRD_IDLE;
        default:
          state_r <= ADCRD_IDLE;
      endcase
    end
  end

  // Busy covers the conversion and a master read-after shift.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      busy_r <= 1'b0;
    else if (state_r == ADCRD_IDLE)
      busy_r <= !cnv_n_s;
    else
      busy_r <= !(conv_done && !m_start)
             && !(state_r == ADCRD_MSHIFT && m_done);
  end

  // The result is replaced only when a conversion completes.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      result_r <= '0;
    else if (conv_done)
      result_r <= conv_data;
  end

  // Master serial clock divider and shifter.
  assign m_done = m_active_r && m_level_r && (m_half_r == '0)
                && (m_bits_r == `ADCRD_CNT_W'(`ADCRD_BITS - 1));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      m_active_r <= 1'b0;
      m_level_r  <= 1'b0;
      m_half_r   <= '0;
      m_bits_r   <= '0;
      m_shift_r  <= '0;
    end
    else if (m_start && !m_active_r)
    begin
      m_active_r <= 1'b1;
      m_level_r  <= 1'b0;
      m_half_r   <= `ADCRD_SCLK_HALF;
      m_bits_r   <= '0;
      m_shift_r  <= conv_done ? fmt_new : fmt_result;
    end
    else if (m_active_r)
    begin
      if (m_half_r != '0)
        m_half_r <= m_half_r - 1'b1;
      else
      begin
        m_half_r  <= `ADCRD_SCLK_HALF;
        m_level_r <= ~m_level_r;
        if (m_level_r)
        begin
          // Next bit appears with the falling edge and holds a full period.
          m_shift_r <= {m_shift_r[`ADCRD_MSB-1:0], 1'b0};
          m_bits_r  <= m_bits_r + 1'b1;
          if (m_done)
            m_active_r <= 1'b0;
        end
      end
    end
  end

  // Host clock edges seen through the synchroniser output.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sclk_d_r <= 1'b1; // Matches the synchroniser reset, so no false edge.
    else
      sclk_d_r <= sclk_s;
  end

  assign s_rise = serial_parallel_select && clock_source_select
                && selected && sclk_s && !sclk_d_r;
  assign s_fall = serial_parallel_select && clock_source_select
                && selected && !sclk_s && sclk_d_r;

  // Slave shifter: chain bit in on the rise, shift out on the fall.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_shift_r <= '0;
      s_cnt_r   <= '0;
      s_chain_r <= 1'b0;
    end
    else if (conv_done || !selected)
    begin
      s_shift_r <= conv_done ? fmt_new : fmt_result;
      s_cnt_r   <= '0;
      s_chain_r <= 1'b0;
    end
    else
    begin
      if (s_rise)
        s_chain_r <= (state_r == ADCRD_IDLE) && rtc_s;
      if (s_fall)
      begin
        s_shift_r <= {s_shift_r[`ADCRD_MSB-1:0], s_chain_r};
        if (s_cnt_r != `ADCRD_CNT_W'(`ADCRD_BITS))
          s_cnt_r <= s_cnt_r + 1'b1;
      end
    end
  end

  // A slave read left unfinished at conversion end pulses late-read.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      late_read_flag_r <= 1'b0;
      late_seen_r      <= 1'b0;
    end
    else
    begin
      late_read_flag_r <= conv_done && serial_parallel_select
                       && clock_source_select && selected
                       && (s_cnt_r != '0)
                       && (s_cnt_r != `ADCRD_CNT_W'(`ADCRD_BITS));
      if (late_read_flag_r)
        late_seen_r <= 1'b1;
      else if (state_r == ADCRD_IDLE && !cnv_n_s)
        late_seen_r <= 1'b0;
    end
  end

  // Parallel bus output with optional byte swap.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      data_out_r <= '0;
      data_oe_r  <= 1'b0;
    end
    else
    begin
      data_oe_r <= selected && !serial_parallel_select;
      if (byte_order_select)
        data_out_r <= {fmt_result[7:0], fmt_result[15:8]};
      else
        data_out_r <= fmt_result;
    end
  end

  // Serial pins, multiplexed onto the bus and floated when deselected.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      serial_data_output_r <= 1'b0;
      serial_oe_r          <= 1'b0;
      sclk_out_r           <= 1'b0;
      sclk_oe_r            <= 1'b0;
      frame_valid_r        <= 1'b0;
    end
    else
    begin
      serial_oe_r <= selected && serial_parallel_select;
      sclk_oe_r   <= selected && serial_parallel_select
                  && !clock_source_select;
      serial_data_output_r <= clock_source_select ? s_shift_r[`ADCRD_MSB]
                           : m_shift_r[`ADCRD_MSB];
      sclk_out_r    <= m_level_r ^ clock_invert;
      frame_valid_r <= m_active_r ^ clock_invert;
    end
  end

  // Status word read back over the register port.
  assign status_w = {19'h00000, s_cnt_r, 5'h00, m_active_r,
                     late_seen_r, busy_r};
endmodule // adcrd_top
`default_nettype wire

// *** tb/adcrd_properties.sv ***
// Pin-level assertions of the readout block.
// Bound into adcrd_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_cfg.svh"
module adcrd_chk (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                cs_n,
  input wire logic                rd_n,
  input wire logic                convert_start_n,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_bvalid,
  input wire logic                busy_r,
  input wire logic [`ADCRD_MSB:0] data_out_r,
  input wire logic                data_oe_r,
  input wire logic                serial_data_output_r,
  input wire logic                serial_oe_r,
  input wire logic                sclk_oe_r,
  input wire logic                late_read_flag_r
);
  logic [7:0] cnt_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Counts the cycles of each busy period.
  always_ff @(posedge clk)
  begin
    if (sys_rst || !busy_r)
      cnt_r <= 8'h00;
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  end
  // Convert-start stays low across the end of a conversion.
  sequence s_held;
    (!convert_start_n) [*4] ##0 $fell(busy_r);
  endsequence
  property p_float;
    data_oe_r || serial_oe_r || sclk_oe_r
      |-> !$past(cs_n, 3) && !$past(rd_n, 3);
  endproperty
  property p_len;
    $fell(busy_r) |-> cnt_r >= `ADCRD_CONV_CYC;
  endproperty
  property p_auto;
    s_held |-> ##[1:4] busy_r;
  endproperty
  property p_pulse;
    late_read_flag_r |=> !late_read_flag_r;
  endproperty
  property p_late_end;
    late_read_flag_r |-> $past(busy_r) || $past(busy_r, 2);
  endproperty
  property p_hold;
    sclk_oe_r && $changed(serial_data_output_r)
      |=> $stable(serial_data_output_r) [*3];
  endproperty
  property p_mux;
    data_oe_r |-> !serial_oe_r;
  endproperty
  property p_keep;
    busy_r && $past(busy_r) && data_oe_r && $past(data_oe_r) &&
      !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) && !s_axi_bvalid
      |-> $stable(data_out_r);
  endproperty
  a_float: assert property (p_float)
    else $error("output enabled while deselected");
  a_len: assert property (p_len)
    else $error("conversion ended early");
  a_auto: assert property (p_auto)
    else $error("no automatic restart");
  a_pulse: assert property (p_pulse)
    else $error("late flag longer than one cycle");
  a_late_end: assert property (p_late_end)
    else $error("late flag away from conversion end");
  a_hold: assert property (p_hold)
    else $error("serial bit changed too soon");
  a_mux: assert property (p_mux)
    else $error("parallel and serial both enabled");
  a_keep: assert property (p_keep)
    else $error("result changed during conversion");
endmodule // adcrd_chk
bind adcrd_top adcrd_chk i_adcrd_chk (.*);
`default_nettype wire

// *** tb/adcrd_host.sv ***
// Host model: selects the device and clocks a serial read at 5 MHz.
// Assumes go is raised by the bench and held until the read may end.
`timescale 1ns/1ps
`default_nettype none
module adcrd_host (
  input  wire logic       go,
  input  wire logic [5:0] nbits,
  input  wire logic       sdo,
  output logic            sclk_in,
  output logic            cs_n,
  output logic            rd_n,
  output logic            done,
  output logic [31:0]     word
);
  // Idle state: deselected, clock parked low.
  initial
  begin
    {sclk_in, done, word} = '0;
    {cs_n, rd_n} = 2'b11;
  end
  // One read: select, then clock nbits bits.
  always @(posedge go)
  begin
    done = 1'b0;
    word = '0;
    cs_n = 1'b0;
    rd_n = 1'b0;
    #400;
    for (int i = 0; i < nbits; i++)
    begin
      sclk_in = 1'b1;
      #100;
      word = {word[30:0], sdo};
      sclk_in = 1'b0;
      #100;
    end
    done = 1'b1;
    @(negedge go);
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
endmodule // adcrd_host
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the readout block.
// Assumes the host model and checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module testbench;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, ph;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, convert_start_n;
  logic cs_n, rd_n, read_timing_or_chain_input, sclk_in, busy_r, go;
  logic data_oe_r, serial_data_output_r, serial_oe_r, sclk_out_r, done;
  logic sclk_oe_r, frame_valid_r, late_read_flag_r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, word, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] conv_data, data_out_r, cap, v, e;
  logic [5:0]  nbits;
  logic [4:0]  c;
  int          num_errors, compares, seed, ncap, bsy, lates, n0, b0, m;
  logic [15:0] res_q[$];
  adcrd_top i_adcrd_top (.*);
  adcrd_host i_adcrd_host (.go, .nbits, .sdo(serial_data_output_r),
    .sclk_in, .cs_n, .rd_n, .done, .word);
  // Clock at 40 MHz.
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Samples the master link; counts pulses.
  always @(posedge clk)
  begin
    ph <= sclk_out_r ^ c[4];
    lates <= lates + late_read_flag_r;
    if (sclk_oe_r && (frame_valid_r ^ c[4]) && (sclk_out_r ^ c[4]) && !ph)
    begin
      cap <= {cap[14:0], serial_data_output_r};
      ncap <= ncap + 1;
      bsy <= bsy + busy_r;
    end
  end
  function automatic logic [15:0] fmt(input logic [15:0] d,
                                      input logic [4:0] f);
    fmt = f[0] ? d : {~d[15], d[14:0]};
  endfunction
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits for host done (sel) or busy to reach val.
  task automatic wt(input bit sel, input bit val);
    m = 0;
    do
    begin
      @(negedge clk);
      m++;
    end while ((sel ? done : busy_r) !== val && m < 600);
    if (m >= 600)
      tmo();
    @(posedge clk);
  endtask
  // One register access.
  task automatic axi(input bit wr, input logic [7:0] a);
    bit t_aw, t_w, t_ar, fin;
    @(posedge clk);
    fin = 1'b0;
    m = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    while (!fin && m < 40)
    begin
      @(negedge clk);
      m++;
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      {t_aw, t_w, t_ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
      @(posedge clk);
      if (t_aw) s_axi_awvalid <= 1'b0;
      if (t_w) s_axi_wvalid <= 1'b0;
      if (t_ar) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (!fin)
      tmo();
  endtask
  task automatic conv(input logic [15:0] d);
    conv_data <= d;
    convert_start_n <= 1'b0;
    wt(0, 1);
    convert_start_n <= 1'b1;
    wt(0, 0);
    res_q.push_back(d);
  endtask
  initial
  begin
    seed = 5;
    {sys_rst, convert_start_n, s_axi_wstrb} = 6'h3f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, go, read_timing_or_chain_input, c} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_data, nbits} = '0;
    tick(4);
    sys_rst <= 1'b0;
    tick(3);
    axi(0, `ADCRD_REG_CTRL);
    `CHK(q, 32'h0)
    axi(0, 8'h0c);
    `CHK({r, q}, {`ADCRD_RESP_SLVERR, 32'h0})
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      c = i[4:0];
      s_axi_wdata <= {27'h0, c};
      axi(1, `ADCRD_REG_CTRL);
      `CHK(r, `ADCRD_RESP_OKAY)
      v = 16'($random(seed));
      conv(v);
      axi(0, `ADCRD_REG_RESULT);
      `CHK(q[15:0], v)
      go <= 1'b1;
      wt(1, 1);
      tick(4);
      e = fmt(v, c);
      `CHK(data_out_r, c[1] ? {e[7:0], e[15:8]} : e)
      `CHK(data_oe_r, 1'b1)
      go <= 1'b0;
      tick(6);
      `CHK(data_oe_r, 1'b0)
    end
    $display("test parallel done");
    c = 5'h0d;
    s_axi_wdata <= {27'h0, c};
    axi(1, `ADCRD_REG_CTRL);
    read_timing_or_chain_input <= 1'b1;
    v = 16'($random(seed));
    conv(v);
    nbits <= 6'd32;
    go <= 1'b1;
    wt(1, 1);
    `CHK(word, {fmt(v, c), 16'hffff})
    go <= 1'b0;
    $display("test slave chain done");
    read_timing_or_chain_input <= 1'b0;
    v = 16'($random(seed));
    conv_data <= v;
    tick(6);
    convert_start_n <= 1'b0;
    wt(0, 1);
    wt(0, 0);
    res_q.push_back(v);
    conv_data <= ~v;
    nbits <= 6'd4;
    go <= 1'b1;
    wt(0, 1);
    convert_start_n <= 1'b1;
    n0 = lates;
    wt(0, 0);
    tick(4);
    e = fmt(v, c);
    `CHK(lates - n0, 1)
    `CHK(word[3:0], e[15:12])
    go <= 1'b0;
    tick(6);
    $display("test late read done");
    for (int k = 0; k < 2; k++)
    begin
      c = k ? 5'h14 : 5'h04;
      s_axi_wdata <= {27'h0, c};
      axi(1, `ADCRD_REG_CTRL);
      read_timing_or_chain_input <= k[0];
      nbits <= 6'd0;
      go <= 1'b1;
      conv(16'($random(seed)));
      n0 = ncap;
      b0 = bsy;
      conv(16'($random(seed)));
      for (int w = 0; w < 200 && ncap - n0 < 16; w++)
        tick(1);
      e = fmt(res_q[$ - k], c);
      `CHK(cap, e)
      `CHK(ncap - n0, 16)
      if (k == 0)
        `CHK(bsy - b0, 16)
      go <= 1'b0;
      tick(6);
    end
    $display("test master done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
